// File: rtl/adsc_ctrl.sv
// Host-side sequencer that configures, starts, reads and stops the converter.
// Assumes a register port: write strobe, read strobe with data one cycle later,
// and the interrupt request flag of the converter as a level.
//
// How it works
// RL1 - Configuration written only while converter idle
// RL2 - Wait 1 us after connecting reference
// RL3 - Disconnect reference only when no conversion runs
// RL4 - Trigger pin set input for external trigger
// RL5 - Analog input pins set to input mode
// RL6 - Conversion clock within limits; sample-hold needs 1 MHz
// RL7 - Mode change rewrites channel and sweep fields
// RL8 - Read results only after request flag set
// RL9 - Repeat modes need undivided main clock
// RL10 - Forced stop makes all results invalid
// RL11 - DMA mode: no external trigger, skip first_result
// RL12 - No conversion during processor wait state
// RL13 - Sample-hold requires main clock no-division code
// RL14 - Single sweep stop: clear start before acknowledging
// RL15 - Key interrupts exclude analog inputs 4 to 7
// RL16 - Start bit begins conversion, or external trigger edge
`timescale 1ns/1ns

module adsc_ctrl
	import adsc_pkg::*;
#(
	parameter int AD_CLK_HZ = 8000000
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             cmd_start_i,
	input  wire logic             cmd_stop_i,
	input  wire logic             cmd_disconnect_i,
	input  wire logic [1:0]       cfg_mode_i,
	input  wire logic [2:0]       cfg_channel_i,
	input  wire logic [1:0]       cfg_sweep_i,
	input  wire logic             cfg_ext_trig_i,
	input  wire logic             cfg_sample_hold_i,
	input  wire logic             cfg_dma_i,
	input  wire logic             cpu_wait_i,
	input  wire logic             cpu_clk_undivided_i,
	input  wire logic             key_int_en_i,
	output logic                  busy_o,
	output logic                  cmd_refused_o,
	output logic                  ref_connected_o,
	output logic                  results_ok_o,
	output logic                  result_valid_o,
	output logic [2:0]            result_channel_o,
	output logic [`ADSC_DATA_W-1:0] result_data_o,
	output logic                  dev_wr_o,
	output logic                  dev_rd_o,
	output logic [`ADSC_ADDR_W-1:0] dev_addr_o,
	output logic [`ADSC_DATA_W-1:0] dev_wdata_o,
	input  wire logic [`ADSC_DATA_W-1:0] dev_rdata_i,
	input  wire logic             dev_irq_flag_i
);

	localparam int SETTLE_CYC = `ADSC_REF_SETTLE_CYC;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (AD_CLK_HZ > `ADSC_ADCLK_MAX_HZ || AD_CLK_HZ < `ADSC_ADCLK_MIN_HZ) begin : g_bad_clk // RL6
		$error("adsc_ctrl: conversion clock outside 250 kHz to 16 MHz");
	end

	// Sample-hold is a run-time choice, so its higher floor is checked per start
	localparam logic SH_ALLOWED = (AD_CLK_HZ >= `ADSC_ADCLK_MIN_SH_HZ); // RL6

	adsc_regs_s s_q;
	adsc_regs_s s_d;
	logic       settle_done;

	adsc_settle_timer #(
		.CYCLES (SETTLE_CYC)
	) u_settle (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.start_i (s_q.tstart),
		.done_o  (settle_done)
	);

	// ----------------------------------------
	// Register images
	// ----------------------------------------
	function automatic adsc_data_t ctl0(input adsc_regs_s s, input logic start);
		adsc_data_t v;
		v = `ADSC_REG_RESET;
		v[`ADSC_C0_CH_LSB +: 3]   = s.ch;
		v[`ADSC_C0_MODE_LSB +: 2] = s.mode;
		v[`ADSC_C0_TRG_BIT]       = s.ext_trigger_select;
		v[`ADSC_C0_START_BIT]     = start;
		return v;
	endfunction

	function automatic adsc_data_t ctl1(input adsc_regs_s s, input logic ref_on);
		adsc_data_t v;
		v = `ADSC_REG_RESET;
		v[`ADSC_C1_SWEEP_LSB +: 2] = s.grp;
		v[`ADSC_C1_REF_BIT]        = ref_on;
		return v;
	endfunction

	// ----------------------------------------
	// Start screening
	// ----------------------------------------
	logic is_sweep;
	logic is_repeat;
	logic uses_hi;
	logic start_bad;

	always_comb begin
		is_sweep  = cfg_mode_i[1];
		is_repeat = cfg_mode_i[0];
		// Sweep group g covers channels 0 to 2g+1
		uses_hi   = is_sweep ? (cfg_sweep_i >= 2'h2) : cfg_channel_i[2];
		start_bad = cpu_wait_i                                 // RL12
			| (cfg_ext_trig_i & cfg_dma_i)                     // RL11
			| (is_repeat & ~cpu_clk_undivided_i)               // RL9
			| (key_int_en_i & uses_hi)                         // RL15
			| (cfg_sample_hold_i & ~SH_ALLOWED);               // RL6
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		s_d         = s_q;
		s_d.wr      = 1'b0;
		s_d.rd      = 1'b0;
		s_d.rvld    = 1'b0;
		s_d.refused = 1'b0;
		s_d.tstart  = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				if (cmd_start_i) begin
					if (start_bad) begin
						s_d.refused = 1'b1;
					end else begin
						s_d.mode      = cfg_mode_i;
						s_d.ch        = cfg_channel_i;
						s_d.grp       = cfg_sweep_i;
						s_d.ext_trigger_select       = cfg_ext_trig_i;
						s_d.sh        = cfg_sample_hold_i;
						s_d.dma       = cfg_dma_i;
						s_d.stop_pend = 1'b0;
						s_d.res_ok    = 1'b0;
						s_d.st        = ST_AIN_DIR;
					end
				end else if (cmd_disconnect_i) begin
					if (s_q.ref_on) begin
						s_d.wr     = 1'b1; // RL3
						s_d.addr   = `ADSC_OFS_CONTROL_1;
						s_d.wdata  = ctl1(s_q, 1'b0);
						s_d.ref_on = 1'b0;
					end else begin
						s_d.refused = 1'b1;
					end
				end else if (cmd_stop_i) begin
					s_d.refused = 1'b1;
				end
			end
			ST_AIN_DIR: begin
				s_d.wr    = 1'b1; // RL5
				s_d.addr  = `ADSC_OFS_AIN_DIR;
				s_d.wdata = `ADSC_AIN_ALL_INPUT;
				s_d.st    = ST_TRIG_DIR;
			end
			ST_TRIG_DIR: begin
				s_d.st = ST_MCD;
				if (s_q.ext_trigger_select) begin
					s_d.wr    = 1'b1; // RL4
					s_d.addr  = `ADSC_OFS_TRIG_DIR;
					s_d.wdata = `ADSC_REG_RESET;
				end
			end
			ST_MCD: begin
				s_d.st = ST_C1;
				if (s_q.sh) begin
					s_d.wr    = 1'b1; // RL13
					s_d.addr  = `ADSC_OFS_MAIN_CLK_DIV;
					s_d.wdata = `ADSC_MCD_NO_DIV;
				end
			end
			ST_C1: begin
				s_d.wr     = 1'b1; // RL1
				s_d.addr   = `ADSC_OFS_CONTROL_1;
				s_d.wdata  = ctl1(s_q, 1'b1);
				s_d.ref_on = 1'b1;
				s_d.tstart = ~s_q.ref_on; // RL2
				s_d.st     = ST_C2;
			end
			ST_C2: begin
				s_d.wr    = 1'b1;
				s_d.addr  = `ADSC_OFS_CONTROL_2;
				s_d.wdata = `ADSC_REG_RESET;
				s_d.wdata[`ADSC_C2_SH_BIT] = s_q.sh;
				s_d.st    = ST_C3;
			end
			ST_C3: begin
				s_d.wr    = 1'b1;
				s_d.addr  = `ADSC_OFS_CONTROL_3;
				s_d.wdata = `ADSC_REG_RESET;
				s_d.wdata[`ADSC_C3_DMA_BIT] = s_q.dma;
				s_d.st    = ST_C0;
			end
			ST_C0: begin
				// Channel field always rewritten, so a mode change reselects pins
				s_d.wr    = 1'b1; // RL7
				s_d.addr  = `ADSC_OFS_CONTROL_0;
				s_d.wdata = ctl0(s_q, 1'b0);
				s_d.st    = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (settle_done && !s_q.tstart) // RL2
					s_d.st = ST_GO;
			end
			ST_GO: begin
				s_d.wr    = 1'b1; // RL16
				s_d.addr  = `ADSC_OFS_CONTROL_0;
				s_d.wdata = ctl0(s_q, 1'b1);
				s_d.st    = ST_RUN;
			end
			ST_RUN: begin
				if (cmd_stop_i) begin
					s_d.st = ST_STOP;
				end else if (dev_irq_flag_i) begin // RL8
					s_d.idx  = s_q.mode[1] ? {2'h0, s_q.dma} : s_q.ch; // RL11
					s_d.last = s_q.mode[1] ? {s_q.grp, 1'b1} : s_q.ch;
					s_d.st   = (s_q.dma && !s_q.mode[1]) ? ST_ACK : ST_READ;
				end
			end
			ST_READ: begin
				s_d.rd   = 1'b1; // RL8
				s_d.addr = `ADSC_OFS_RESULT_BASE + {5'h00, s_q.idx};
				s_d.st   = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				if (!s_q.rd) begin
					s_d.rvld   = 1'b1;
					s_d.rdata  = dev_rdata_i;
					s_d.rch    = s_q.idx;
					s_d.res_ok = 1'b1;
					s_d.idx    = s_q.idx + 3'h1;
					s_d.st     = (s_q.idx == s_q.last) ? ST_ACK : ST_READ;
				end
			end
			ST_ACK: begin
				// Flag acknowledged after results are read, after start is cleared, or at once in single-channel DMA mode
				s_d.wr    = 1'b1; // RL14
				s_d.addr  = `ADSC_OFS_INT_CONTROL;
				s_d.wdata = `ADSC_REG_RESET;
				s_d.st    = ST_HOLD;
			end
			ST_HOLD: begin
				// One cycle lets the cleared flag reach the input before it is sampled
				s_d.st = (s_q.stop_pend || !s_q.mode[0]) ? ST_IDLE : ST_RUN;
			end
			ST_STOP: begin
				s_d.wr        = 1'b1; // RL14
				s_d.addr      = `ADSC_OFS_CONTROL_0;
				s_d.wdata     = ctl0(s_q, 1'b0);
				s_d.res_ok    = 1'b0; // RL10
				s_d.stop_pend = 1'b1;
				s_d.st        = ST_ACK;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		if (s_q.st != ST_IDLE && s_q.st != ST_RUN && (cmd_start_i || cmd_disconnect_i))
			s_d.refused = 1'b1; // RL1
		if (s_q.st == ST_RUN && (cmd_start_i || cmd_disconnect_i))
			s_d.refused = 1'b1; // RL3
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			s_q <= '{st: ST_IDLE, default: '0};
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign busy_o           = (s_q.st != ST_IDLE);
	assign cmd_refused_o    = s_q.refused;
	assign ref_connected_o  = s_q.ref_on;
	assign results_ok_o     = s_q.res_ok;
	assign result_valid_o   = s_q.rvld;
	assign result_channel_o = s_q.rch;
	assign result_data_o    = s_q.rdata;
	assign dev_wr_o         = s_q.wr;
	assign dev_rd_o         = s_q.rd;
	assign dev_addr_o       = s_q.addr;
	assign dev_wdata_o      = s_q.wdata;

endmodule

// File: rtl/adsc_map.svh
// Offsets, field positions, codes and timing of the converter register map.
// Assumes an 8-bit register port on the converter side.
`ifndef ADSC_MAP_SVH
`define ADSC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADSC_ADDR_W           8
`define ADSC_DATA_W           8
`define ADSC_OFS_CONTROL_0    8'h00
`define ADSC_OFS_CONTROL_1    8'h01
`define ADSC_OFS_CONTROL_2    8'h02
`define ADSC_OFS_CONTROL_3    8'h03
`define ADSC_OFS_CONTROL_4    8'h04
`define ADSC_OFS_INT_CONTROL  8'h05
`define ADSC_OFS_RESULT_BASE  8'h08
`define ADSC_OFS_AIN_DIR      8'h10
`define ADSC_OFS_TRIG_DIR     8'h11
`define ADSC_OFS_MAIN_CLK_DIV 8'h12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADSC_C0_CH_LSB        0
`define ADSC_C0_MODE_LSB      3
`define ADSC_C0_TRG_BIT       5
`define ADSC_C0_START_BIT     6
`define ADSC_C1_SWEEP_LSB     0
`define ADSC_C1_REF_BIT       5
`define ADSC_C2_SH_BIT        0
`define ADSC_C3_DMA_BIT       0
`define ADSC_TRIG_DIR_BIT     0

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define ADSC_MODE_ONE_SHOT    2'h0
`define ADSC_MODE_REPEAT      2'h1
`define ADSC_MODE_SWEEP       2'h2
`define ADSC_MODE_REP_SWEEP   2'h3
`define ADSC_MCD_NO_DIV       8'h12
`define ADSC_AIN_ALL_INPUT    8'h00
`define ADSC_REG_RESET        8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADSC_CLK_MHZ          50
`define ADSC_T_REF_SETTLE_NS  1000
`define ADSC_REF_SETTLE_CYC   ((`ADSC_T_REF_SETTLE_NS * `ADSC_CLK_MHZ + 999) / 1000)
`define ADSC_ADCLK_MAX_HZ     16000000
`define ADSC_ADCLK_MIN_HZ     250000
`define ADSC_ADCLK_MIN_SH_HZ  1000000

`endif

// File: rtl/adsc_pkg.sv
// Types shared by the converter sequencing controller.
// Assumes adsc_map.svh is on the include path.
`include "adsc_map.svh"

package adsc_pkg;

	typedef enum logic [3:0] {
		ST_IDLE, ST_AIN_DIR, ST_TRIG_DIR, ST_MCD, ST_C1, ST_C2, ST_C3, ST_C0,
		ST_SETTLE, ST_GO, ST_RUN, ST_READ, ST_CAPTURE, ST_ACK, ST_HOLD, ST_STOP
	} adsc_state_e;

	typedef logic [`ADSC_ADDR_W-1:0] adsc_addr_t;
	typedef logic [`ADSC_DATA_W-1:0] adsc_data_t;

	typedef struct packed {
		adsc_state_e st;
		logic        ref_on;
		logic [1:0]  mode;
		logic [2:0]  ch;
		logic [1:0]  grp;
		logic        ext_trigger_select;
		logic        sh;
		logic        dma;
		logic [2:0]  idx;
		logic [2:0]  last;
		logic        stop_pend;
		logic        res_ok;
		logic        wr;
		logic        rd;
		adsc_addr_t  addr;
		adsc_data_t  wdata;
		logic        rvld;
		adsc_data_t  rdata;
		logic [2:0]  rch;
		logic        refused;
		logic        tstart;
	} adsc_regs_s;

endpackage

// File: rtl/adsc_settle_timer.sv
// Down counter for the reference settling wait.
// Assumes start_i is a one-cycle pulse from the sequencer.
`timescale 1ns/1ns

module adsc_settle_timer #(
	parameter int CYCLES = 50
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic start_i,
	output logic      done_o
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// Refused at elaboration: a zero wait would let a start through at once
	if (CYCLES < 1) begin : g_bad_cycles
		$error("adsc_settle_timer: CYCLES must be at least 1");
	end

	always_comb begin
		cnt_d = cnt_q;
		if (start_i)
			cnt_d = CW'(CYCLES);
		else if (cnt_q != '0)
			cnt_d = cnt_q - CW'(1);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign done_o = (cnt_q == '0);

endmodule

// File: tb/adsc_ctrl_asserts.sv
// Checker for the converter register port and command refusals.
// Assumes it is bound to adsc_ctrl and sees its ports only.
`timescale 1ns/1ns

module adsc_ctrl_asserts (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic       cmd_start_i,
	input wire logic [1:0] cfg_mode_i,
	input wire logic [2:0] cfg_channel_i,
	input wire logic       cpu_wait_i,
	input wire logic       cpu_clk_undivided_i,
	input wire logic       key_int_en_i,
	input wire logic       cmd_refused_o,
	input wire logic       results_ok_o,
	input wire logic       dev_wr_o,
	input wire logic       dev_rd_o,
	input wire logic [7:0] dev_addr_o,
	input wire logic [7:0] dev_wdata_o,
	input wire logic       dev_irq_flag_i
);
	// ----
	// Shadow of what was written
	// ----
	logic [5:0] cnt_q;
	logic [7:0] mcd_q;
	logic       ref_q, run_q, rep_q, sh_q, dma_q, sel_q;
	wire  [7:0] a = dev_addr_o;
	wire  [7:0] d = dev_wdata_o;
	wire        go = dev_wr_o && a == 8'h00 && d[6];
	wire        halt = dev_wr_o && a == 8'h00 && !d[6] && run_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{cnt_q, mcd_q, ref_q, run_q, rep_q, sh_q, dma_q, sel_q} <= '0;
		end else begin
			// Saturates so a long idle never wraps into a short wait
			if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
			if (dev_wr_o && a == 8'h01) begin
				ref_q <= d[5];
				if (d[5] && !ref_q) cnt_q <= 6'h00;
			end
			if (dev_wr_o && a == 8'h02) sh_q <= d[0];
			if (dev_wr_o && a == 8'h03) dma_q <= d[0];
			if (dev_wr_o && a == 8'h12) mcd_q <= d;
			// Channel or sweep field rewritten since the last start
			if (dev_wr_o && (a == 8'h01 || (a == 8'h00 && !d[6]))) sel_q <= 1'b1;
			if (go) sel_q <= 1'b0;
			if (go) begin
				run_q <= 1'b1;
				rep_q <= d[3];
			end else if (halt || (dev_irq_flag_i && !rep_q)) begin
				run_q <= 1'b0;
			end
		end
	end

	a_cfg_idle: assert property (dev_wr_o && a inside {[8'h01:8'h04]} |-> !run_q)
		else $error("config written during conversion");
	a_ref_settle: assert property (go |-> ref_q && cnt_q >= 6'h31)
		else $error("start too soon after reference connect");
	a_ref_drop: assert property (dev_wr_o && a == 8'h01 && !d[5] && ref_q |-> !run_q)
		else $error("reference cut during conversion");
	a_trig_input: assert property (dev_wr_o && a == 8'h11 |-> d[0] == 1'b0)
		else $error("trigger pin not input");
	a_ain_input: assert property (dev_wr_o && a == 8'h10 |-> d == 8'h00)
		else $error("analog pins not input");
	a_read_done: assert property (dev_rd_o && a[7:3] == 5'h01 |-> dev_irq_flag_i)
		else $error("result read before completion");
	a_clk_refuse: assert property (cmd_start_i && cfg_mode_i[0] && !cpu_clk_undivided_i
		|=> cmd_refused_o)
		else $error("repeat start with divided clock taken");
	a_stop_invalid: assert property (halt |-> !results_ok_o)
		else $error("results still valid after stop");
	a_dma_first: assert property (dev_rd_o && a == 8'h08 |-> !dma_q)
		else $error("first result read in dma mode");
	a_wait_refuse: assert property (cmd_start_i && cpu_wait_i |=> cmd_refused_o)
		else $error("start in wait state taken");
	a_sh_nodiv: assert property (go && sh_q |-> mcd_q == 8'h12)
		else $error("sample hold without undivided clock");
	a_stop_ack: assert property (halt |=> dev_wr_o && a == 8'h05)
		else $error("flag not cleared right after stop");
	a_key_refuse: assert property (cmd_start_i && key_int_en_i && !cfg_mode_i[1]
		&& cfg_channel_i[2] |=> cmd_refused_o)
		else $error("key pin channel start taken");
	a_mode_resel: assert property (go |-> sel_q)
		else $error("start without input pin reselect");
endmodule

bind adsc_ctrl adsc_ctrl_asserts adsc_ctrl_asserts_inst (.*);

// File: tb/adsc_dev_model.sv
// Behavioural converter: control register, completion flag, results.
// Assumes the controller's write strobe and one-cycle read latency.
`timescale 1ns/1ns

module adsc_dev_model (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] conv_cyc_i,
	input  wire logic       trig_pin_i,
	output logic [7:0]      rdata_o,
	output logic            irq_o
);
	logic [7:0] c0_q, cnt_q;
	logic       trg_q, bad_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{c0_q, cnt_q, trg_q, bad_q, irq_o, rdata_o} <= '0;
		end else begin
			trg_q <= trig_pin_i;
			// Idle bus toggles so stale data never looks valid
			rdata_o <= ~rdata_o;
			if (rd_i) rdata_o <= bad_q ? 8'h3c : {5'h0a, addr_i[2:0]};
			if (cnt_q > 8'h01) cnt_q <= cnt_q - 8'h01;
			if (cnt_q == 8'h01) begin
				cnt_q <= 8'h00;
				irq_o <= 1'b1;
			end
			if (c0_q[6] && c0_q[5] && trig_pin_i && !trg_q) cnt_q <= conv_cyc_i;
			if (wr_i && addr_i == 8'h00) begin
				c0_q <= wdata_i;
				if (wdata_i[6] && !wdata_i[5]) cnt_q <= conv_cyc_i;
				if (wdata_i[6]) bad_q <= 1'b0;
				if (!wdata_i[6]) cnt_q <= 8'h00;
				if (!wdata_i[6] && cnt_q != 8'h00) bad_q <= 1'b1;
			end
			if (wr_i && addr_i == 8'h05) begin
				irq_o <= 1'b0;
				if (c0_q[6] && c0_q[3]) cnt_q <= conv_cyc_i;
			end
		end
	end
endmodule

// File: tb/testbench.sv
// Testbench: sequencing controller driving the converter model.
// Assumes rtl/ on the include path.
`timescale 1ns/1ns

module testbench;
	wire         busy_o, cmd_refused_o, ref_connected_o, results_ok_o;
	wire         result_valid_o, dev_wr_o, dev_rd_o, dev_irq_flag_i;
	wire  [2:0]  result_channel_o;
	wire  [7:0]  result_data_o, dev_addr_o, dev_wdata_o, dev_rdata_i;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        cmd_start_i = 1'b0;
	logic        cmd_stop_i = 1'b0;
	logic        cmd_disconnect_i = 1'b0;
	logic        trig = 1'b0;
	logic [12:0] cfg_q = 13'h0000;
	logic [7:0]  conv = 8'h04;
	logic [2:0]  exp_ch = 3'h0;
	int          nres = 0;
	int          fail_count = 0;
	int          checked = 0;

	always #10 clk_i = ~clk_i;

	adsc_ctrl adsc_ctrl_inst (
		.*,
		.cpu_wait_i          (cfg_q[12]),
		.cfg_ext_trig_i      (cfg_q[11]),
		.cfg_dma_i           (cfg_q[10]),
		.key_int_en_i        (cfg_q[9]),
		.cfg_sample_hold_i   (cfg_q[8]),
		.cpu_clk_undivided_i (cfg_q[7]),
		.cfg_mode_i          (cfg_q[6:5]),
		.cfg_channel_i       (cfg_q[4:2]),
		.cfg_sweep_i         (cfg_q[1:0])
	);

	adsc_dev_model adsc_dev_model_inst (
		.clk_i, .rst_b_i, .wr_i(dev_wr_o), .rd_i(dev_rd_o), .addr_i(dev_addr_o),
		.wdata_i(dev_wdata_o), .conv_cyc_i(conv), .trig_pin_i(trig),
		.rdata_o(dev_rdata_i), .irq_o(dev_irq_flag_i)
	);

	// ----
	// Shared steps
	// ----
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic go(input logic [12:0] v);
		cfg_q = v;
		cmd_start_i = 1'b1;
		tick();
		cmd_start_i = 1'b0;
	endtask

	task automatic idle_in(input int n);
		for (int i = 0; i < n && busy_o !== 1'b0; i++) tick();
		chk("busy", 8'h00, {7'h0, busy_o});
	endtask

	task automatic run(input string s, input logic [12:0] v, input logic [2:0] c, input int n);
		nres = 0;
		exp_ch = c;
		go(v);
		chk("busy", 8'h01, {7'h0, busy_o});
		idle_in(2000);
		chk("count", n[7:0], nres[7:0]);
		chk("ok", 8'h01, {7'h0, results_ok_o});
		$display("%s done", s);
	endtask

	always @(negedge clk_i) begin
		if (result_valid_o === 1'b1) begin
			chk("chan", {5'h0, exp_ch}, {5'h0, result_channel_o});
			chk("data", {5'h0a, exp_ch}, result_data_o);
			if (cfg_q[6]) exp_ch = exp_ch + 3'h1;
			nres++;
		end
	end

	// ----
	// Scenarios
	// ----
	task automatic t_ext();
		nres = 0;
		exp_ch = 3'h2;
		go(13'h0888);
		tick(100);
		chk("early", 8'h00, nres[7:0]);
		go(13'h0888);
		chk("refused", 8'h01, {7'h0, cmd_refused_o});
		trig = 1'b1;
		tick(2);
		trig = 1'b0;
		idle_in(200);
		chk("count", 8'h01, nres[7:0]);
		$display("ext done");
	endtask

	task automatic t_disc();
		cmd_disconnect_i = 1'b1;
		tick();
		cmd_disconnect_i = 1'b0;
		tick(3);
		chk("ref", 8'h00, {7'h0, ref_connected_o});
		cmd_disconnect_i = 1'b1;
		tick();
		cmd_disconnect_i = 1'b0;
		chk("refused", 8'h01, {7'h0, cmd_refused_o});
		$display("disc done");
	endtask

	task automatic t_stop();
		conv = 8'hc8;
		nres = 0;
		exp_ch = 3'h1;
		go(13'h00a4);
		for (int i = 0; i < 1000 && nres < 2; i++) tick();
		tick(4);
		cmd_stop_i = 1'b1;
		tick();
		cmd_stop_i = 1'b0;
		// Cleared together with the stop write, one edge after the request
		tick();
		chk("ok", 8'h00, {7'h0, results_ok_o});
		idle_in(10);
		chk("count", 8'h02, nres[7:0]);
		$display("stop done");
	endtask

	task automatic t_refuse();
		logic [12:0] tab [5] = '{13'h1080, 13'h0c80, 13'h0020, 13'h0290, 13'h02c2};
		foreach (tab[i]) begin
			go(tab[i]);
			chk("refused", 8'h01, {7'h0, cmd_refused_o});
			chk("busy", 8'h00, {7'h0, busy_o});
			tick();
		end
		$display("refuse done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		tick(2);
		rst_b_i = 1'b1;
		run("oneshot", 13'h018c, 3'h3, 1);
		t_ext();
		t_disc();
		run("sweep", 13'h00c1, 3'h0, 4);
		run("dma", 13'h04c1, 3'h1, 3);
		t_stop();
		t_refuse();
		wrap_up();
	end

	initial begin
		#400000;
		fail_count++;
		wrap_up();
	end
endmodule
